//--- src/ioxp_pkg.sv
// Constants and carrier types shared by the I/O expander port logic.
// Assumes one 50 MHz clock and a plain byte-wide register port.
package ioxp_pkg;

    // Bits per port and number of ports.
    localparam int PORT_W = 8;
    localparam int NPORTS = 2;
    // Register address width; bit 4 selects port B.
    localparam int ADDR_W = 5;
    localparam int BANK_BIT = 4;

    // Register offsets inside one port bank.
    localparam logic [3:0] OFS_DIR = 4'h0;
    localparam logic [3:0] OFS_IRQ_EN = 4'h2;
    localparam logic [3:0] OFS_DEF = 4'h3;
    localparam logic [3:0] OFS_SRC = 4'h4;
    localparam logic [3:0] OFS_CFG = 4'h5;
    localparam logic [3:0] OFS_PULLUP = 4'h6;
    localparam logic [3:0] OFS_FLAGS = 4'h7;
    localparam logic [3:0] OFS_CAPTURE = 4'h8;
    localparam logic [3:0] OFS_PINS = 4'h9;
    localparam logic [3:0] OFS_LATCH = 4'hA;

    // Field positions in the configuration register.
    localparam int CFG_MIRROR_BIT = 6;
    localparam int CFG_ODR_BIT = 2;
    localparam int CFG_POL_BIT = 1;
    // Bit 0 of the configuration register is unimplemented.
    localparam logic [7:0] CFG_WMASK = 8'hFE;

    // Reset values.
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Nominal weak pull-up, for the pad designer; logic only gates it.
    localparam int PULLUP_KOHM = 100;

    // Comparison setup of one port.
    typedef struct packed {
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] irq_en;
        logic [PORT_W-1:0] def_val;
        logic [PORT_W-1:0] src_sel;
    } ioxp_cmp_cfg_t;

    // Interrupt state that one port shows to the register file.
    typedef struct packed {
        logic [PORT_W-1:0] level;
        logic [PORT_W-1:0] flags;
        logic [PORT_W-1:0] capture;
        logic pending;
    } ioxp_irq_view_t;

endpackage

//--- src/ioxp_port_irq.sv
// Change detector for one port: pin synchroniser, reference, flags, capture.
// Assumes the clear strobe is a one-cycle pulse from the register file.
`timescale 1ns/100ps
`default_nettype none

module ioxp_port_irq
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Raw pin levels and comparison setup.
    input wire logic [ioxp_pkg::PORT_W-1:0] pin_i,
    input wire ioxp_pkg::ioxp_cmp_cfg_t cfg_i,
    // Read of the pins or capture register of this port.
    input wire logic clear_i,
    // Interrupt state.
    output var ioxp_pkg::ioxp_irq_view_t view_o
);

    localparam int W = ioxp_pkg::PORT_W;

    logic [W-1:0] meta_r; // First synchroniser stage, read only by sync_r.
    logic [W-1:0] sync_r; // Synchronised pin levels.
    logic [W-1:0] prev_r; // Previous-value reference.
    logic [W-1:0] flags_r; // Pins that caused the pending interrupt.
    logic [W-1:0] cap_r; // Pin levels caught at the interrupt.
    logic pend_r; // Internal interrupt of this port.
    logic [W-1:0] armed; // Inputs enabled for change detection.
    logic [W-1:0] diff_ref; // Mismatch against the live reference.
    logic [W-1:0] diff_new; // Mismatch once the reference is renewed.
    logic [W-1:0] hit;
    logic [W-1:0] prev_nxt;
    logic [W-1:0] flags_nxt;
    logic [W-1:0] cap_nxt;
    logic pend_nxt;
    logic load;

    // Only enabled inputs take part; outputs never do.
    assign armed = cfg_i.irq_en & cfg_i.dir;
    // Each bit compares with its default or with its previous value.
    assign diff_ref = armed & (cfg_i.src_sel & (sync_r ^ cfg_i.def_val) |
        ~cfg_i.src_sel & (sync_r ^ prev_r));
    // After a clear, change-mode bits restart from the current level, so
    // only default-mode mismatches survive the clear.
    assign diff_new = armed & cfg_i.src_sel & (sync_r ^ cfg_i.def_val);
    // A clear re-arms at once; otherwise only the first event is taken.
    assign hit = clear_i ? diff_new : diff_ref;
    assign load = (clear_i | ~pend_r) & (|hit);
    assign pend_nxt = load | (pend_r & ~clear_i);
    assign flags_nxt = load ? hit : (clear_i ? ioxp_pkg::RST_ZERO : flags_r);
    assign cap_nxt = load ? sync_r : cap_r;
    // The reference is frozen while an interrupt is pending, renewed on
    // clear, and follows the pins while idle.
    assign prev_nxt = (clear_i | ~(pend_r | load)) ? sync_r : prev_r;

    // Two-stage synchroniser; the raw pins are asynchronous.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r <= ioxp_pkg::RST_ZERO;
            sync_r <= ioxp_pkg::RST_ZERO;
        end
        else
        begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end

    // Interrupt state registers.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prev_r <= ioxp_pkg::RST_ZERO;
            flags_r <= ioxp_pkg::RST_ZERO;
            cap_r <= ioxp_pkg::RST_ZERO;
            pend_r <= 1'b0;
        end
        else
        begin
            prev_r <= prev_nxt;
            flags_r <= flags_nxt;
            cap_r <= cap_nxt;
            pend_r <= pend_nxt;
        end
    end

    // One driver for the whole view, in field order: level, flags,
    // capture, pending.
    assign view_o = {sync_r, flags_r, cap_r, pend_r};

endmodule

`default_nettype wire

//--- src/ioxp_top.sv
// Two-port I/O expander core: registers, pin drive and interrupt outputs.
// Assumes a serial front end that issues one-cycle register strobes.
//
// Operation
// - Pull-up only on enabled input pins.
// - Flag bit set for each pin causing interrupt.
// - Flag register ignores all writes.
// - Capture loads on interrupt, holds until cleared.
// - Pins read returns levels; write goes to latch.
// - Latch read returns latch; latch drives outputs.
// - Each port has own interrupt, cleared by read.
// - Unmirrored: port A to A, B to B.
// - Mirrored: both outputs carry A or B.
// - Mirrored: each read clears only its port.
// - Change mode compares enabled pin with previous.
// - Default mode compares enabled pin with default.
// - Only enabled inputs may cause interrupts.
// - Clear takes effect at end of read.
// - Writes never affect a pending interrupt.
// - First event captures; later ones ignored until clear.
// - Only default mismatch re-sets and recaptures after clear.
// - Clear renews the previous-value reference.
// - Default mismatch persists across reads.
// - Outputs selectable high, low or open-drain.
// - Open-drain overrides polarity; polarity picks level.
// - Source bit one selects default compare.
// - Enable bit one arms change detection.
`timescale 1ns/100ps
`default_nettype none

module ioxp_top
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port.
    input wire logic [ioxp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ioxp_pkg::PORT_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ioxp_pkg::PORT_W-1:0] rdata_o,
    // Port A pins.
    input wire logic [ioxp_pkg::PORT_W-1:0] port_a_pins_i,
    output logic [ioxp_pkg::PORT_W-1:0] port_a_pins_o,
    output logic [ioxp_pkg::PORT_W-1:0] port_a_pins_oe_o,
    output logic [ioxp_pkg::PORT_W-1:0] port_a_pullup_o,
    // Port B pins.
    input wire logic [ioxp_pkg::PORT_W-1:0] port_b_pins_i,
    output logic [ioxp_pkg::PORT_W-1:0] port_b_pins_o,
    output logic [ioxp_pkg::PORT_W-1:0] port_b_pins_oe_o,
    output logic [ioxp_pkg::PORT_W-1:0] port_b_pullup_o,
    // Interrupt outputs.
    output logic irq_out_a_o,
    output logic irq_out_a_oe_o,
    output logic irq_out_b_o,
    output logic irq_out_b_oe_o
);

    localparam int W = ioxp_pkg::PORT_W;
    localparam int NP = ioxp_pkg::NPORTS;

    // Interrupt pad drive: open-drain pulls low only while active and
    // floats otherwise; push-pull always drives, at the chosen polarity.
    function automatic logic [1:0] irq_drive(input logic active,
        input logic open_drain_select, input logic pol);
        logic [1:0] res;
        res = 2'b00;
        if (open_drain_select)
        begin
            res = {1'b0, active};
        end
        else
        begin
            res = {~(active ^ pol), 1'b1};
        end
        return res;
    endfunction

    // Per-port registers, one copy for each port; configuration and read data are shared.
    logic [W-1:0] dir_r [NP]; // One marks an input pin.
    logic [W-1:0] irq_en_r [NP]; // Change interrupt enables.
    logic [W-1:0] def_r [NP]; // Default compare values.
    logic [W-1:0] src_r [NP]; // Compare source select.
    logic [W-1:0] pullup_r [NP]; // Pull-up enables.
    logic [W-1:0] latch_r [NP]; // Output latches.
    logic [W-1:0] cfg_r; // Shared configuration register.
    logic [W-1:0] rdata_r; // Registered read data.
    logic [W-1:0] rdata_nxt;
    logic [W-1:0] cfg_nxt;

    // Address decode.
    logic sel_b; // Access targets port B.
    logic [3:0] ofs; // Offset within the port bank.
    logic hit_cfg; // Either copy of the configuration address.
    logic [NP-1:0] wr_port; // Write aimed at a port.
    logic [NP-1:0] clr_port; // Read that clears a port.

    // Interrupt routing.
    logic mirror;
    logic open_drain_select;
    logic pol;
    logic irq_a_act;
    logic irq_b_act;
    logic [1:0] drv_a;
    logic [1:0] drv_b;

    // Detector views and settings.
    ioxp_pkg::ioxp_cmp_cfg_t cmp_cfg [NP];
    ioxp_pkg::ioxp_irq_view_t view [NP];
    logic [W-1:0] pins_raw [NP];
    ioxp_pkg::ioxp_irq_view_t rview; // View of the addressed port.

    // Bit 4 of the address picks the bank; the low nibble the register.
    assign sel_b = addr_i[ioxp_pkg::BANK_BIT];
    assign ofs = addr_i[3:0];
    assign hit_cfg = (ofs == ioxp_pkg::OFS_CFG);

    // Write and clear strobes per port.
    assign wr_port = sel_b ? {wr_i, 1'b0} : {1'b0, wr_i};
    // A read of the pins or capture register clears only its own port;
    // writes to those registers take no part here.
    assign clr_port = (rd_i & (ofs == ioxp_pkg::OFS_PINS |
        ofs == ioxp_pkg::OFS_CAPTURE)) ?
        (sel_b ? 2'b10 : 2'b01) : 2'b00;

    // Configuration: the unimplemented bit stays zero.
    assign cfg_nxt = (wr_i & hit_cfg) ? (wdata_i & ioxp_pkg::CFG_WMASK) :
        cfg_r;

    // Configuration fields.
    assign mirror = cfg_r[ioxp_pkg::CFG_MIRROR_BIT];
    assign open_drain_select = cfg_r[ioxp_pkg::CFG_ODR_BIT];
    assign pol = cfg_r[ioxp_pkg::CFG_POL_BIT];

    // Raw pins into the detectors.
    assign pins_raw[0] = port_a_pins_i;
    assign pins_raw[1] = port_b_pins_i;

    // Per-port register writes. Flags and capture have no write path, so
    // a write to them is dropped.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int p = 0; p < NP; p++)
            begin
                dir_r[p] <= ioxp_pkg::RST_DIR;
                irq_en_r[p] <= ioxp_pkg::RST_ZERO;
                def_r[p] <= ioxp_pkg::RST_ZERO;
                src_r[p] <= ioxp_pkg::RST_ZERO;
                pullup_r[p] <= ioxp_pkg::RST_ZERO;
                latch_r[p] <= ioxp_pkg::RST_ZERO;
            end
        end
        else
        begin
            for (int p = 0; p < NP; p++)
            begin
                if (wr_port[p])
                begin
                    unique case (ofs)
                        ioxp_pkg::OFS_DIR: dir_r[p] <= wdata_i;
                        ioxp_pkg::OFS_IRQ_EN: irq_en_r[p] <= wdata_i;
                        ioxp_pkg::OFS_DEF: def_r[p] <= wdata_i;
                        ioxp_pkg::OFS_SRC: src_r[p] <= wdata_i;
                        ioxp_pkg::OFS_PULLUP: pullup_r[p] <= wdata_i;
                        // Both pin and latch writes land in the latch.
                        ioxp_pkg::OFS_PINS: latch_r[p] <= wdata_i;
                        ioxp_pkg::OFS_LATCH: latch_r[p] <= wdata_i;
                        // Flags, capture and unmapped: ignored.
                        default: latch_r[p] <= latch_r[p];
                    endcase
                end
            end
        end
    end

    // Shared configuration and read data.
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cfg_r <= ioxp_pkg::RST_ZERO;
            rdata_r <= ioxp_pkg::RST_ZERO;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // One change detector per port.
    for (genvar g = 0; g < NP; g++)
    begin : g_port
        // One driver per element, in field order: dir, enable, default,
        // source.
        assign cmp_cfg[g] = {dir_r[g], irq_en_r[g], def_r[g], src_r[g]};

        ioxp_port_irq u_irq
        (
            .mclk_i(mclk_i),
            .rst_n_i(rst_n_i),
            .pin_i(pins_raw[g]),
            .cfg_i(cmp_cfg[g]),
            .clear_i(clr_port[g]),
            .view_o(view[g])
        );
    end

    // Read selection; the value is what the register held in the strobe
    // cycle, so a clearing read still returns the captured byte.
    assign rview = sel_b ? view[1] : view[0];

    always_comb
    begin
        rdata_nxt = ioxp_pkg::RST_ZERO;
        if (rd_i)
        begin
            if (hit_cfg)
            begin
                rdata_nxt = cfg_r;
            end
            else if (sel_b)
            begin
                unique case (ofs)
                    ioxp_pkg::OFS_DIR: rdata_nxt = dir_r[1];
                    ioxp_pkg::OFS_IRQ_EN: rdata_nxt = irq_en_r[1];
                    ioxp_pkg::OFS_DEF: rdata_nxt = def_r[1];
                    ioxp_pkg::OFS_SRC: rdata_nxt = src_r[1];
                    ioxp_pkg::OFS_PULLUP: rdata_nxt = pullup_r[1];
                    ioxp_pkg::OFS_FLAGS: rdata_nxt = rview.flags;
                    ioxp_pkg::OFS_CAPTURE: rdata_nxt = rview.capture;
                    ioxp_pkg::OFS_PINS: rdata_nxt = rview.level;
                    ioxp_pkg::OFS_LATCH: rdata_nxt = latch_r[1];
                    default: rdata_nxt = ioxp_pkg::RST_ZERO;
                endcase
            end
            else
            begin
                unique case (ofs)
                    ioxp_pkg::OFS_DIR: rdata_nxt = dir_r[0];
                    ioxp_pkg::OFS_IRQ_EN: rdata_nxt = irq_en_r[0];
                    ioxp_pkg::OFS_DEF: rdata_nxt = def_r[0];
                    ioxp_pkg::OFS_SRC: rdata_nxt = src_r[0];
                    ioxp_pkg::OFS_PULLUP: rdata_nxt = pullup_r[0];
                    ioxp_pkg::OFS_FLAGS: rdata_nxt = rview.flags;
                    ioxp_pkg::OFS_CAPTURE: rdata_nxt = rview.capture;
                    ioxp_pkg::OFS_PINS: rdata_nxt = rview.level;
                    ioxp_pkg::OFS_LATCH: rdata_nxt = latch_r[0];
                    default: rdata_nxt = ioxp_pkg::RST_ZERO;
                endcase
            end
        end
    end

    assign rdata_o = rdata_r;

    // Interrupt routing: separate per port, or both outputs carry the OR.
    // In mirrored mode each port's own signal is still cleared only by
    // its own read, so the OR stays active until both are read.
    assign irq_a_act = mirror ? (view[0].pending | view[1].pending) :
        view[0].pending;
    assign irq_b_act = mirror ? (view[0].pending | view[1].pending) :
        view[1].pending;
    assign drv_a = irq_drive(irq_a_act, open_drain_select, pol);
    assign drv_b = irq_drive(irq_b_act, open_drain_select, pol);

    assign irq_out_a_o = drv_a[1];
    assign irq_out_a_oe_o = drv_a[0];
    assign irq_out_b_o = drv_b[1];
    assign irq_out_b_oe_o = drv_b[0];

    // Pin drive: latches drive the outputs; inputs float.
    assign port_a_pins_o = latch_r[0];
    assign port_a_pins_oe_o = ~dir_r[0];
    assign port_b_pins_o = latch_r[1];
    assign port_b_pins_oe_o = ~dir_r[1];

    // The weak pull-up is only meaningful on an input pin, and keeping it
    // off on outputs saves current against a driven low.
    assign port_a_pullup_o = pullup_r[0] & dir_r[0];
    assign port_b_pullup_o = pullup_r[1] & dir_r[1];

endmodule

`default_nettype wire

//--- sim/ioxp_pin_model.sv
// Far-side model of one port: an external source that drives pin levels.
// Assumes a pad enable that is high while the port logic drives the pin.
`timescale 1ns/100ps
`default_nettype none

module ioxp_pin_model
(
    // Clock.
    input wire logic mclk_i,
    // External source: levels and a mask of the pins it drives.
    input wire logic [7:0] ext_i,
    input wire logic [7:0] ext_en_i,
    // Pad controls from the port logic.
    input wire logic [7:0] out_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pu_i,
    // Resolved pin levels.
    output logic [7:0] pin_o
);
    // A floating pin toggles every cycle, so a stale level never passes.
    logic [7:0] wander_r = 8'h5a;

    // The wander pattern flips on each clock.
    always_ff @(posedge mclk_i)
    begin
        wander_r <= ~wander_r;
    end

    // Port drive wins, then the external source, then the weak pull-up.
    assign pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_i)
        | (~oe_i & ~ext_en_i & (pu_i | wander_r));
endmodule

`default_nettype wire

//--- sim/ioxp_top_assertions.sv
// Port-level checks of the expander core, bound to its top module.
// Assumes one-cycle register strobes, never both at once.
`timescale 1ns/100ps
`default_nettype none

module ioxp_top_assertions
(
    // Clock, reset and register port.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [ioxp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ioxp_pkg::PORT_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ioxp_pkg::PORT_W-1:0] rdata_o,
    // Pin drive of both ports.
    input wire logic [ioxp_pkg::PORT_W-1:0] port_a_pins_o,
    input wire logic [ioxp_pkg::PORT_W-1:0] port_a_pullup_o,
    input wire logic [ioxp_pkg::PORT_W-1:0] port_a_pins_oe_o,
    input wire logic [ioxp_pkg::PORT_W-1:0] port_b_pins_o,
    input wire logic [ioxp_pkg::PORT_W-1:0] port_b_pins_oe_o,
    // Interrupt pads.
    input wire logic irq_out_a_o,
    input wire logic irq_out_a_oe_o,
    input wire logic irq_out_b_o,
    input wire logic irq_out_b_oe_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_RDATA_IDLE:
        assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    AST_LATCH_WR_A:
        assert property (wr_i && addr_i == 5'h0a
            |=> port_a_pins_o == $past(wdata_i))
        else $error("latch write did not reach port A pins");
    AST_PINS_WR_B:
        assert property (wr_i && addr_i == 5'h19
            |=> port_b_pins_o == $past(wdata_i))
        else $error("pins write did not reach port B latch");
    AST_LATCH_HOLD_A:
        assert property (!$past(wr_i) |-> $stable(port_a_pins_o))
        else $error("port A latch moved without a write");
    AST_LATCH_RD_A:
        assert property (rd_i && addr_i == 5'h0a
            |=> rdata_o == $past(port_a_pins_o))
        else $error("latch read differs from latch");
    AST_PULLUP_A:
        assert property ((port_a_pullup_o & port_a_pins_oe_o) == 8'h00)
        else $error("pull-up on an output pin");
    AST_OD_A:
        assert property (!irq_out_a_oe_o |-> !irq_out_a_o)
        else $error("pad A released but driving high");
    AST_OD_B:
        assert property (!irq_out_b_oe_o |-> !irq_out_b_o)
        else $error("pad B released but driving high");
    AST_DIR_B:
        assert property ($changed(port_b_pins_oe_o)
            |-> $past(wr_i) && $past(addr_i) == 5'h10)
        else $error("port B direction moved without a write");

    // Main scenarios: latch write, open-drain release, direction change.
    COV_LATCH: cover property (wr_i && addr_i == 5'h0a);
    COV_OD: cover property (!irq_out_b_oe_o);
    COV_DIR: cover property ($changed(port_b_pins_oe_o));
endmodule

bind ioxp_top ioxp_top_assertions chk (.mclk_i, .rst_n_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .port_a_pins_o, .port_a_pullup_o,
    .port_a_pins_oe_o, .port_b_pins_o, .port_b_pins_oe_o, .irq_out_a_o,
    .irq_out_a_oe_o, .irq_out_b_o, .irq_out_b_oe_o);

`default_nettype wire

//--- sim/port_pullup_and_change_interrupt_bench.sv
// Self-checking bench of the expander core with two pin models.
// Assumes the register map and one-cycle read latency of the core.
`timescale 1ns/100ps
`default_nettype none

module port_pullup_and_change_interrupt_bench;
    // Bus, pins and pads.
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o, port_a_pins_i, port_a_pins_o, port_a_pins_oe_o;
    logic [7:0] port_a_pullup_o, port_b_pins_i, port_b_pins_o;
    logic [7:0] port_b_pins_oe_o, port_b_pullup_o;
    logic irq_out_a_o, irq_out_a_oe_o, irq_out_b_o, irq_out_b_oe_o;
    // External levels, drive mask, config shadow and scratch values.
    logic [7:0] drv_a = 8'h00, drv_b = 8'h00, en_a = 8'hff;
    logic [7:0] cfg = 8'h00, rd_v, lat;
    logic [7:0] cfg_list [4] = '{8'h02, 8'h04, 8'h06, 8'h00};
    int bad_count = 0, n_checks = 0;
    int seed = 32'hca34;

    // The clock toggles every 10 ns, a period of 20 ns.
    always #10 mclk_i = ~mclk_i;

    ioxp_top uut (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .port_a_pins_i, .port_a_pins_o, .port_a_pins_oe_o,
        .port_a_pullup_o, .port_b_pins_i, .port_b_pins_o, .port_b_pins_oe_o,
        .port_b_pullup_o, .irq_out_a_o, .irq_out_a_oe_o, .irq_out_b_o,
        .irq_out_b_oe_o);
    ioxp_pin_model pm_a (.mclk_i, .ext_i(drv_a), .ext_en_i(en_a),
        .out_i(port_a_pins_o), .oe_i(port_a_pins_oe_o),
        .pu_i(port_a_pullup_o), .pin_o(port_a_pins_i));
    ioxp_pin_model pm_b (.mclk_i, .ext_i(drv_b), .ext_en_i(8'hff),
        .out_i(port_b_pins_o), .oe_i(port_b_pins_oe_o),
        .pu_i(port_b_pullup_o), .pin_o(port_b_pins_i));

    // Expected pad pair {level, enable} for the current config.
    function automatic logic [1:0] pad(input logic act);
        pad = cfg[2] ? {1'b0, act} : {(cfg[1] ? act : ~act), 1'b1};
    endfunction

    // Prints the verdict and stops; a watchdog may call it too.
    task automatic complete_run;
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // One-cycle read strobe; data is taken in the following cycle only.
    task automatic rd(input logic [4:0] a);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask

    // Compares both interrupt pads against the expected activity.
    task automatic pads(input logic a, input logic b);
        #1 chk({4'h0, irq_out_a_o, irq_out_a_oe_o, irq_out_b_o,
            irq_out_b_oe_o}, {4'h0, pad(a), pad(b)});
    endtask

    // Five edges cover the two synchroniser flops and the pending flop.
    task automatic settle;
        repeat (5) @(posedge mclk_i);
    endtask

    // Watchdog against a hang.
    initial
    begin
        #2000000;
        bad_count++;
        complete_run();
    end

    initial
    begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        pads(1'b0, 1'b0);
        // Pull-up and capture reset values of both banks read back as zero.
        foreach (cfg_list[i])
        begin
            rd({i[0], 4'h6 + {2'b00, i[1], 1'b0}});
            chk(rd_v, 8'h00);
        end
        wr(5'h00, 8'h0f);
        wr(5'h10, 8'h00);
        // Random latches: read back, and output pins follow them.
        repeat (4)
        begin
            lat = $random(seed);
            drv_a <= $random(seed);
            wr(5'h0a, lat);
            wr(5'h19, ~lat);
            rd(5'h0a);
            chk(rd_v, lat);
            rd(5'h09);
            chk(rd_v, {lat[7:4], drv_a[3:0]});
            rd(5'h1a);
            chk(rd_v, ~lat);
            chk(port_b_pins_o, ~lat);
        end
        // Undriven inputs with pull-ups read high; outputs get none.
        drv_a <= 8'h00;
        en_a <= 8'hfc;
        wr(5'h06, 8'h33);
        settle();
        chk(port_a_pullup_o, 8'h03);
        rd(5'h09);
        chk({6'h00, rd_v[1:0]}, 8'h03);
        en_a <= 8'hff;
        // Flag register ignores writes.
        wr(5'h07, 8'hff);
        rd(5'h07);
        chk(rd_v, 8'h00);
        // Change mode on port A; bit 4 is an output and must stay silent.
        wr(5'h02, 8'h13);
        lat = lat ^ 8'h10;
        wr(5'h0a, lat);
        settle();
        pads(1'b0, 1'b0);
        drv_a <= 8'h01;
        settle();
        pads(1'b1, 1'b0);
        rd(5'h07);
        chk(rd_v, 8'h01);
        drv_a <= 8'h03;
        settle();
        wr(5'h08, 8'hff);
        pads(1'b1, 1'b0);
        rd(5'h08);
        chk(rd_v, {lat[7:4], 4'h1});
        pads(1'b0, 1'b0);
        settle();
        pads(1'b0, 1'b0);
        drv_a <= 8'h02;
        settle();
        rd(5'h08);
        chk(rd_v, {lat[7:4], 4'h2});
        // Default compare on port B with mirrored pads.
        wr(5'h10, 8'hff);
        wr(5'h14, 8'h01);
        wr(5'h12, 8'h01);
        wr(5'h05, 8'h40);
        cfg = 8'h40;
        drv_a <= 8'h00;
        drv_b <= 8'h01;
        settle();
        pads(1'b1, 1'b1);
        rd(5'h19);
        pads(1'b1, 1'b1);
        rd(5'h17);
        chk(rd_v, 8'h01);
        drv_b <= 8'h00;
        settle();
        rd(5'h18);
        chk(rd_v, 8'h01);
        pads(1'b1, 1'b1);
        wr(5'h05, 8'h00);
        cfg = 8'h00;
        pads(1'b1, 1'b0);
        // Pad styles while port A stays pending.
        foreach (cfg_list[i])
        begin
            wr(5'h05, cfg_list[i]);
            cfg = cfg_list[i];
            pads(1'b1, 1'b0);
        end
        rd(5'h09);
        pads(1'b0, 1'b0);
        complete_run();
    end
endmodule

`default_nettype wire
